// ==== mied_pkg.sv ====
// Operation
// R1 - sensor type 00 selects position/sensorless; other values select speed sensor
// R2 - two-bit input select routes one of three phase inputs to detector
// R3 - encoder outputs must connect only to phase inputs a and b
// R4 - comparator stays off until clock enable or reference enable is set
// R5 - threshold code picks seven internal levels; all ones selects external pin
// R6 - zero crossings sampled only inside the measurement window
// R7 - current mode samples at window rate; voltage mode at pwm rate
// R8 - demag detection samples comparator at selectable sensing frequency; the code uses a fixed strobe of one in SCF_DIV (4) clocks
// R9 - demag must precede zero crossing; order commutation, demag, zero crossing
// R10 - edge polarity and same polarity bits classify comparator edges as demag or zc
// R11 - every commutation starts demag blanking window; reset length 200 us
// R12 - window codes: 5 us steps to 40, then 20 us steps 60 to 200
// R13 - after window count consecutive demag samples, flag at limit; reset limit 1
// R14 - demag event limit equals field value plus one, 1 to 16
// R15 - counter only for hardware demag; simulated demag uses limit one
// R16 - sensor mode bypasses blanking window and demag event counter
// R17 - preloaded input select fields take effect at next commutation
// R18 - any demag event sets demag flag; interrupt when mask set
// R19 - sensing strobe derived from peripheral clock
package mied_pkg;
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          WIN_STEP_NS   = 5000;
  localparam int          WIN_STEP2_NS  = 20000;
  localparam int          WIN_STEP_CYC  = (WIN_STEP_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int          WIN_STEP2_CYC = (WIN_STEP2_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam logic [3:0]  ADR_CTRL_A    = 4'h0;
  localparam logic [3:0]  ADR_PARITY    = 4'h1;
  localparam logic [3:0]  ADR_PHASE     = 4'h2;
  localparam logic [3:0]  ADR_CTRL_C    = 4'h3;
  localparam logic [3:0]  ADR_PRESC     = 4'h4;
  localparam logic [3:0]  ADR_DFILT     = 4'h5;
  localparam logic [3:0]  ADR_STATUS    = 4'h6;
  localparam logic [3:0]  ADR_CLEAR     = 4'h7;
  localparam logic [3:0]  ADR_ENABLE    = 4'h8;
  localparam logic [3:0]  ADR_EVENT     = 4'h9;
  localparam int          CA_SENSOR_BIT = 0;
  localparam int          CA_CKE_BIT    = 1;
  localparam int          CA_DAC_BIT    = 2;
  localparam int          CA_VMODE_BIT  = 3;
  localparam int          PH_EDGE_BIT   = 2;
  localparam int          PH_SAME_BIT   = 3;
  localparam int          ST_D_BIT      = 0;
  localparam int          ST_Z_BIT      = 1;
  localparam int          ST_C_BIT      = 2;
  localparam logic [7:0]  RST_CTRL_A    = 8'h00;
  localparam logic [7:0]  RST_PHASE     = 8'h00;
  localparam logic [7:0]  RST_CTRL_C    = 8'h00;
  localparam logic [7:0]  RST_PRESC     = 8'h00;
  localparam logic [7:0]  RST_DFILT     = 8'hF0;
  localparam logic [2:0]  VR_EXTERNAL   = 3'h7;
  localparam logic [1:0]  TYPE_POSITION = 2'h0;
  localparam int          SCF_DIV       = 4;
  typedef enum logic [1:0] {MIED_WAIT_C, MIED_BLANK, MIED_WAIT_D, MIED_WAIT_Z} mied_state_t;

  function automatic logic [11:0] mied_win_cycles(input logic [3:0] code);
    if (code[3] == 1'b0)
      mied_win_cycles = 12'((code[2:0] + 1) * WIN_STEP_CYC); // R12
    else
      mied_win_cycles = 12'((code[2:0] + 3) * WIN_STEP2_CYC); // R12
  endfunction : mied_win_cycles
endpackage : mied_pkg

// ==== mied_top.sv ====
`timescale 1ns/1ns
module mied_top
  import mied_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_phase_input_a,
  input  wire logic        i_phase_input_b,
  input  wire logic        i_phase_input_c,
  input  wire logic        i_cmp_out,
  input  wire logic        i_meas_window,
  input  wire logic        i_pwm_tick,
  input  wire logic        i_win_tick,
  input  wire logic        i_commutate,
  input  wire logic        i_sim_demag,
  output logic [7:0]       o_rdata,
  output logic [1:0]       o_cmp_sel,
  output logic [2:0]       o_threshold,
  output logic             o_ext_ref,
  output logic             o_cmp_en,
  output logic             o_speed_mode,
  output logic             o_dig_in,
  output logic             o_irq
);
  ////////////////////////////////////////////////////////////////
  logic [7:0]  ctrl_a_ff, parity_ff, phase_pre_ff, phase_ff, ctrl_c_ff, presc_ff, dfilt_ff;
  logic [2:0]  stat_ff, ien_ff;
  logic [7:0]  rdata_ff;
  logic [1:0]  pa_s_ff, pb_s_ff, pc_s_ff, cmp_s_ff;
  logic [1:0]  scf_cnt_ff;
  logic [11:0] win_cnt_ff;
  logic [4:0]  ev_cnt_ff;
  logic        prev_cmp_ff;
  mied_state_t st_ff, nxt_st;

  wire         sensor_mode   = ctrl_a_ff[CA_SENSOR_BIT];
  wire         speed_mode    = parity_ff[1:0] != TYPE_POSITION; // R1
  wire         cmp_en        = ctrl_a_ff[CA_CKE_BIT] | ctrl_a_ff[CA_DAC_BIT]; // R4
  wire         cmp           = cmp_s_ff[1];
  wire [1:0]   in_sel        = phase_ff[1:0];
  wire         edge_pol      = phase_ff[PH_EDGE_BIT];
  wire         same_pol      = phase_ff[PH_SAME_BIT];
  // digital mux for tacho; encoder uses a and b only
  wire         dig_sel       = (in_sel == 2'h0) ? pa_s_ff[1] :
                               (in_sel == 2'h1) ? pb_s_ff[1] : pc_s_ff[1]; // R2
  wire         scf_tick      = scf_cnt_ff == 2'(SCF_DIV - 1); // R19
  // zero crossing level is the edge polarity; demag is opposite unless same polarity
  wire         z_level       = edge_pol; // R10
  wire         d_level       = same_pol ? edge_pol : ~edge_pol; // R10
  wire         z_sample      = ctrl_a_ff[CA_VMODE_BIT] ? i_pwm_tick : i_win_tick; // R7
  wire         d_hit         = scf_tick & cmp_en & (cmp == d_level); // R8
  wire         d_miss        = scf_tick & ~(cmp == d_level);
  wire [4:0]   d_limit       = {1'b0, dfilt_ff[3:0]} + 5'h01; // R14
  wire         d_hw          = d_hit & (sensor_mode | (ev_cnt_ff + 5'h01 >= d_limit)); // R13 R16
  wire         demag_evt     = (st_ff == MIED_WAIT_D) & (d_hw | i_sim_demag); // R15 R18
  wire         z_evt         = (st_ff == MIED_WAIT_Z) & z_sample & i_meas_window & cmp_en
                               & (cmp == z_level) & (prev_cmp_ff != z_level); // R6 R9
  wire [2:0]   evt_vec       = {i_commutate, z_evt, demag_evt};
  wire         clr_wr        = i_wr & (i_addr == ADR_CLEAR);
  wire [2:0]   nxt_stat      = evt_vec | (stat_ff & ~(clr_wr ? i_wdata[2:0] : 3'h0)); // R18
  wire [7:0]   rd_mux        = (i_addr == ADR_CTRL_A) ? ctrl_a_ff :
                               (i_addr == ADR_PARITY) ? parity_ff :
                               (i_addr == ADR_PHASE)  ? phase_pre_ff :
                               (i_addr == ADR_CTRL_C) ? ctrl_c_ff :
                               (i_addr == ADR_PRESC)  ? presc_ff :
                               (i_addr == ADR_DFILT)  ? dfilt_ff :
                               (i_addr == ADR_STATUS) ? {5'h00, stat_ff} :
                               (i_addr == ADR_ENABLE) ? {5'h00, ien_ff} :
                               (i_addr == ADR_EVENT)  ? {2'h0, st_ff, 4'h0} : 8'h00;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      MIED_WAIT_C: nxt_st = st_ff;
      MIED_BLANK:  if (sensor_mode || win_cnt_ff == 12'h001) nxt_st = MIED_WAIT_D; // R11 R16
      MIED_WAIT_D: if (demag_evt) nxt_st = MIED_WAIT_Z; // R9
      MIED_WAIT_Z: if (z_evt) nxt_st = MIED_WAIT_C; // R9
      default:     nxt_st = MIED_WAIT_C;
    endcase
    if (i_commutate) nxt_st = MIED_BLANK; // R11
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pa_s_ff  <= 2'h0;
      pb_s_ff  <= 2'h0;
      pc_s_ff  <= 2'h0;
      cmp_s_ff <= 2'h0;
    end else begin
      pa_s_ff  <= {pa_s_ff[0], i_phase_input_a};
      pb_s_ff  <= {pb_s_ff[0], i_phase_input_b};
      pc_s_ff  <= {pc_s_ff[0], i_phase_input_c};
      cmp_s_ff <= {cmp_s_ff[0], i_cmp_out};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_a_ff    <= RST_CTRL_A;
      parity_ff    <= 8'h00;
      phase_pre_ff <= RST_PHASE;
      phase_ff     <= RST_PHASE;
      ctrl_c_ff    <= RST_CTRL_C;
      presc_ff     <= RST_PRESC;
      dfilt_ff     <= RST_DFILT;
      ien_ff       <= 3'h0;
    end else begin
      if (i_wr && i_addr == ADR_CTRL_A) ctrl_a_ff <= i_wdata;
      if (i_wr && i_addr == ADR_PARITY) parity_ff <= i_wdata;
      if (i_wr && i_addr == ADR_PHASE) phase_pre_ff <= i_wdata;
      if (i_wr && i_addr == ADR_CTRL_C) ctrl_c_ff <= i_wdata;
      if (i_wr && i_addr == ADR_PRESC) presc_ff <= i_wdata;
      if (i_wr && i_addr == ADR_DFILT) dfilt_ff <= i_wdata;
      if (i_wr && i_addr == ADR_ENABLE) ien_ff <= i_wdata[2:0];
      // selection applied only at commutation so the mux never flips mid-step
      if (i_commutate) phase_ff <= phase_pre_ff; // R17
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_ff       <= MIED_WAIT_C;
      win_cnt_ff  <= 12'h000;
      ev_cnt_ff   <= 5'h00;
      scf_cnt_ff  <= 2'h0;
      prev_cmp_ff <= 1'b0;
      stat_ff     <= 3'h0;
      rdata_ff    <= 8'h00;
    end else begin
      st_ff       <= nxt_st;
      scf_cnt_ff  <= scf_tick ? 2'h0 : scf_cnt_ff + 2'h1; // R19
      // samples outside the window are not samples at all, so they must not hide an edge
      if (z_sample && i_meas_window) prev_cmp_ff <= cmp; // R6
      if (i_commutate) win_cnt_ff <= mied_win_cycles(dfilt_ff[7:4]); // R11 R12
      else if (win_cnt_ff != 12'h000) win_cnt_ff <= win_cnt_ff - 12'h001;
      if (i_commutate || d_miss || demag_evt || st_ff != MIED_WAIT_D) ev_cnt_ff <= 5'h00; // R13
      else if (d_hit) ev_cnt_ff <= ev_cnt_ff + 5'h01;
      stat_ff     <= nxt_stat;
      rdata_ff    <= i_rd ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cmp_sel    <= 2'h0;
      o_threshold  <= 3'h0;
      o_ext_ref    <= 1'b0;
      o_cmp_en     <= 1'b0;
      o_speed_mode <= 1'b0;
      o_dig_in     <= 1'b0;
      o_irq        <= 1'b0;
    end else begin
      o_cmp_sel    <= in_sel; // R2
      o_threshold  <= ctrl_c_ff[2:0]; // R5
      o_ext_ref    <= ctrl_c_ff[2:0] == VR_EXTERNAL; // R5
      o_cmp_en     <= cmp_en; // R4
      o_speed_mode <= speed_mode; // R1
      o_dig_in     <= dig_sel;
      o_irq        <= |(nxt_stat & ien_ff); // R18
    end
  end
  assign o_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////
  a_demag_order: assert property (@(posedge i_clk) disable iff (i_rst) // R9
    (st_ff == MIED_WAIT_D && !demag_evt && !i_commutate) |=> st_ff == MIED_WAIT_D) else $error("zc before demag");
  a_demag_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    demag_evt |=> stat_ff[ST_D_BIT]) else $error("demag flag not set"); // R18
  a_blank_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_ff == MIED_BLANK && !sensor_mode && win_cnt_ff > 12'h001 && !i_commutate)
    |=> st_ff == MIED_BLANK) else $error("blank ended early"); // R11
  a_sensor_bypass: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_ff == MIED_BLANK && sensor_mode && !i_commutate) |=> st_ff == MIED_WAIT_D) else $error("blank not bypassed"); // R16
  a_cmp_off: assert property (@(posedge i_clk) disable iff (i_rst)
    !cmp_en |=> !o_cmp_en) else $error("comparator on"); // R4
  a_sel_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_commutate |=> $stable(phase_ff)) else $error("select changed"); // R17
  a_irq_level: assert property (@(posedge i_clk) disable iff (i_rst) // R18
    ##1 o_irq == |($past(nxt_stat) & $past(ien_ff))) else $error("irq mismatch");
  a_speed_sel: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 o_speed_mode == ($past(parity_ff[1:0]) != TYPE_POSITION)) else $error("mode wrong"); // R1
endmodule : mied_top

// ==== mied_motor_model.sv ====
`timescale 1ns/1ns
module mied_motor_model (
  input  wire logic       i_clk,
  input  wire logic       i_cmp_en,
  input  wire logic [1:0] i_cmp_sel,
  input  wire logic [2:0] i_volts,
  output logic            o_phase_a,
  output logic            o_phase_b,
  output logic            o_phase_c,
  output logic            o_cmp
);
  logic junk_ff = 1'b0;
  // a comparator that is off has no steady level, so it toggles every cycle
  always_ff @(posedge i_clk) begin
    junk_ff <= ~junk_ff;
  end
  assign {o_phase_c, o_phase_b, o_phase_a} = i_volts;
  assign o_cmp = !i_cmp_en ? junk_ff : (i_cmp_sel == 2'h3) ? ~junk_ff : i_volts[i_cmp_sel];
endmodule : mied_motor_model

// ==== testbench.sv ====
`timescale 1ns/1ns
module testbench
  import mied_pkg::*;
;
  typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] r; logic [5:0] o;} mied_row_t;
  logic       i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_meas_window = 1'b0, i_pwm_tick = 1'b0;
  logic       i_win_tick = 1'b0, i_commutate = 1'b0, i_sim_demag = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata, rv;
  logic [2:0] volts = 3'h2, o_threshold;
  logic [1:0] o_cmp_sel;
  logic       i_phase_input_a, i_phase_input_b, i_phase_input_c, i_cmp_out;
  logic       o_ext_ref, o_cmp_en, o_speed_mode, o_dig_in, o_irq;
  int         err_count = 0, samples_checked = 0, cyc = 0;
  mied_row_t  rows [9] = '{'{ADR_CTRL_A, 8'h02, 8'h02, 6'h20}, '{ADR_CTRL_A, 8'h04, 8'h04, 6'h20},
    '{ADR_CTRL_A, 8'h00, 8'h00, 6'h00}, '{ADR_PARITY, 8'h01, 8'h01, 6'h10}, '{ADR_PARITY, 8'h03, 8'h03, 6'h10},
    '{ADR_PARITY, 8'h00, 8'h00, 6'h00}, '{ADR_CTRL_C, 8'h07, 8'h07, 6'h0F}, '{ADR_CTRL_C, 8'h06, 8'h06, 6'h06},
    '{4'hA, 8'hFF, 8'h00, 6'h06}};

  mied_top mied_top_i (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .i_phase_input_a, .i_phase_input_b,
    .i_phase_input_c, .i_cmp_out, .i_meas_window, .i_pwm_tick, .i_win_tick, .i_commutate, .i_sim_demag,
    .o_rdata, .o_cmp_sel, .o_threshold, .o_ext_ref, .o_cmp_en, .o_speed_mode, .o_dig_in, .o_irq);
  mied_motor_model mied_motor_model_i (.i_clk(i_clk), .i_cmp_en(o_cmp_en), .i_cmp_sel(o_cmp_sel),
    .i_volts(volts), .o_phase_a(i_phase_input_a), .o_phase_b(i_phase_input_b),
    .o_phase_c(i_phase_input_c), .o_cmp(i_cmp_out));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #50 i_clk = ~i_clk;
  end
  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 rv = o_rdata;
  endtask : rd
  // 0 commutation, 1 simulated demag, 2 sample tick
  task automatic pulse(input int which);
    @(posedge i_clk);
    {i_win_tick, i_sim_demag, i_commutate} <= 3'b001 << which;
    @(posedge i_clk);
    {i_win_tick, i_sim_demag, i_commutate} <= 3'b000;
  endtask : pulse
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : settle
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(ADR_DFILT);
    chk("filter reset", 8'hF0, rv);
    rd(ADR_STATUS);
    chk("status reset", 8'h00, rv);
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d);
      rd(rows[k].a);
      chk("readback", rows[k].r, rv);
      chk("outputs", {2'h0, rows[k].o}, {2'h0, o_cmp_en, o_speed_mode, o_ext_ref, o_threshold});
    end
    wr(ADR_CTRL_A, 8'h02);
    wr(ADR_PHASE, 8'h01);
    settle(4);
    chk("select preload", 8'h00, {6'h0, o_cmp_sel});
    pulse(0);
    settle(4);
    chk("select", 8'h01, {6'h0, o_cmp_sel});
    chk("digital in", 8'h01, {7'h0, o_dig_in});
    wr(ADR_DFILT, 8'h01);
    wr(ADR_CLEAR, 8'h07);
    pulse(0);
    settle(40);
    rd(ADR_STATUS);
    chk("blanked", 8'h00, {6'h0, rv[1:0]});
    settle(40);
    rd(ADR_STATUS);
    chk("demag", 8'h01, {6'h0, rv[1:0]});
    i_meas_window <= 1'b1;
    pulse(2);
    i_meas_window <= 1'b0;
    volts         <= 3'h0;
    settle(3);
    pulse(2);
    rd(ADR_STATUS);
    chk("zc outside", 8'h01, {6'h0, rv[1:0]});
    i_meas_window <= 1'b1;
    pulse(2);
    rd(ADR_STATUS);
    chk("zc", 8'h03, {6'h0, rv[1:0]});
    wr(ADR_ENABLE, 8'h01);
    settle(2);
    chk("irq on", 8'h01, {7'h0, o_irq});
    wr(ADR_ENABLE, 8'h00);
    settle(2);
    chk("irq masked", 8'h00, {7'h0, o_irq});
    wr(ADR_ENABLE, 8'h01);
    wr(ADR_CLEAR, 8'h07);
    settle(2);
    chk("irq cleared", 8'h00, {7'h0, o_irq});
    wr(ADR_CTRL_A, 8'h03);
    volts <= 3'h2;
    wr(ADR_DFILT, 8'hFF);
    wr(ADR_CLEAR, 8'h07);
    pulse(0);
    settle(20);
    rd(ADR_STATUS);
    chk("sensor demag", 8'h01, {7'h0, rv[0]});
    wr(ADR_CTRL_A, 8'h02);
    volts <= 3'h0;
    wr(ADR_DFILT, 8'h0F);
    wr(ADR_CLEAR, 8'h07);
    pulse(0);
    settle(60);
    pulse(1);
    settle(3);
    rd(ADR_STATUS);
    chk("sim demag", 8'h01, {7'h0, rv[0]});
    stop_test();
  end
endmodule : testbench
